// file: verilog/sdpc_pkg.sv
// shared constants, command codes and pin bundles for the sdram pin command decoder
package sdpc_pkg;

  // widths of the pin groups
  localparam int BANK_W = 3;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int NUM_BANKS = 8;

  // address pin roles
  localparam int APRE_BIT = 10;
  localparam int CHOP_BIT = 12;
  localparam int COL_W = 10;

  // mode register selection by bank pins during a mode register set
  localparam logic [2:0] MR_ONE_SEL = 3'h1;
  localparam logic [2:0] MR_TWO_SEL = 3'h2;
  localparam logic [13:0] MR_RESET = 14'h0000;

  // mode register field positions
  localparam int TSTRB_BIT = 11;
  localparam logic [13:0] ONE_RTT_MASK = 14'h0244;
  localparam logic [13:0] TWO_RTT_MASK = 14'h0600;

  // burst lengths, full and chopped
  localparam logic [3:0] BURST_FULL = 4'h8;
  localparam logic [3:0] BURST_CHOP = 4'h4;

  // internal byte store: bank plus low column bits
  localparam int COL_USED = 5;
  localparam int MEM_AW = BANK_W + COL_USED;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // precharge time and its count on the link clock
  localparam int LINK_PERIOD_NS = 160;
  localparam int PRECHARGE_NS = 320;
  localparam int PRE_RAW = (PRECHARGE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int PRE_CYCLES = (PRE_RAW < 1) ? 1 : PRE_RAW;
  localparam logic [3:0] PRE_LAST = 4'(PRE_CYCLES - 1);

  // apb register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam int CTRL_DECODE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int ST_BANK_LSB = 0;
  localparam int ST_TERM_BIT = 8;
  localparam int ST_TSTRB_BIT = 9;
  localparam int ST_BUSY_BIT = 10;
  localparam int ST_W = 11;

  // decoded operation
  typedef enum {
    CMD_DESELECT,
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_PRECHARGE,
    CMD_READ,
    CMD_WRITE,
    CMD_MRS,
    CMD_OTHER
  } sdpc_cmd_t;

  // per bank state
  typedef enum {
    BANK_IDLE,
    BANK_ACTIVE,
    BANK_PRECHG
  } sdpc_bank_st_t;

  // command and address pins sampled on the link clock, with no clock crossing
  typedef struct packed {
    logic chip_sel_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_sel_n;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
  } sdpc_cmd_pins_t;

  // status carried from the link domain to the bus domain
  typedef struct packed {
    logic busy;
    logic term_strobe_en;
    logic termination_on;
    logic [NUM_BANKS-1:0] bank_active;
  } sdpc_status_t;

endpackage

// file: verilog/sdpc_mem.sv
// byte store for the link side, registered read data
`timescale 1ns/1ps
module sdpc_mem
  import sdpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic re,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  // storage array, no reset
  logic [DATA_W-1:0] store [MEM_DEPTH];
  // next read data
  logic [DATA_W-1:0] next_rdata;

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      store[addr] <= wdata;
    end
  end

  // read data held unless a read is asked
  always_comb begin
    next_rdata = rdata;
    if (re) begin
      next_rdata = store[addr];
    end
  end

  // read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// file: verilog/sdpc_top.sv
// sdram pin command decoder: link side decode, banks, burst data path, apb status
// Functional notes
// R1 - read/write samples burst chop, low chops
// R2 - chip select high masks every command
// R3 - command pins sampled on link clock
// R4 - activate opens selected bank
// R5 - precharge closes bank after precharge time
// R6 - column access: write select picks read/write
// R7 - strobe pair driven with reads, qualifies writes
// R8 - termination strobe on disables byte mask
// R9 - mode_reg_one bit eleven enables termination strobe
// R10 - masked write beats leave bytes unchanged
// R11 - eight data pins, byte maskable writes
// R12 - registered termination enable applies termination
// R13 - termination enable ignored when both disabled
// R14 - reset pin low resets device asynchronously
// R15 - auto precharge select: after access, all banks
// R16 - bank pins pick one of eight banks
// R17 - address carries row, column or opcode
// R18 - clock gate low freezes state next cycle
// R19 - all strobes high is no operation
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sdpc_top
  import sdpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_clk,
  input wire logic mem_reset_n,
  input wire logic clock_gate_en,
  input wire sdpc_cmd_pins_t cmd_pins,
  input wire logic die_termination_en,
  input wire logic byte_mask,
  input wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic data_strobe_in,
  output logic data_strobe_out,
  output logic data_strobe_oe,
  input wire logic data_strobe_n_in,
  output logic data_strobe_n_out,
  output logic data_strobe_n_oe,
  output logic termination_on,
  output logic term_strobe_en
);

  // ---------------- link domain reset ----------------
  // release of the reset pin is synchronised, assertion is immediate
  logic rst_meta;
  logic link_rst_n;

  // R14 async reset pin
  always_ff @(posedge mem_clk or negedge mem_reset_n) begin
    if (!mem_reset_n) begin
      rst_meta <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      link_rst_n <= rst_meta;
    end
  end

  // ---------------- bus to link crossing ----------------
  logic ctrl_decode_en; // bus side control bit
  logic dec_meta; // first stage, read only by second
  logic dec_en; // decoder enable in link domain

  // two flops for the decode enable level
  always_ff @(posedge mem_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dec_meta <= 1'b1;
      dec_en <= 1'b1;
    end else begin
      dec_meta <= ctrl_decode_en;
      dec_en <= dec_meta;
    end
  end

  // ---------------- input sampling ----------------
  logic cke_q; // clock gate sampled last edge
  logic dte_q; // termination enable registered
  logic next_cke_q;
  logic next_dte_q;
  logic run; // internal clock running

  // sampled control pins
  always_comb begin
    next_cke_q = clock_gate_en;
    next_dte_q = die_termination_en;
  end

  // R18 clock gate registered
  always_ff @(posedge mem_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cke_q <= 1'b1;
      dte_q <= 1'b0;
    end else begin
      cke_q <= next_cke_q;
      dte_q <= next_dte_q;
    end
  end

  // R18 state advances only while the gate was high
  assign run = cke_q;

  // ---------------- command decode ----------------
  sdpc_cmd_t cmd; // decoded operation this edge
  logic cmd_live; // command may act this edge

  // R3 pins taken at the link clock rising edge
  always_comb begin
    cmd = CMD_OTHER;
    // R2 chip select high masks everything
    if (cmd_pins.chip_sel_n) begin
      cmd = CMD_DESELECT;
    end else begin
      unique case ({cmd_pins.row_strobe_n, cmd_pins.column_strobe_n, cmd_pins.write_sel_n})
        // R4 activate code
        3'b011: cmd = CMD_ACTIVATE;
        // R5 precharge code
        3'b010: cmd = CMD_PRECHARGE;
        // R6 read and write codes
        3'b101: cmd = CMD_READ;
        3'b100: cmd = CMD_WRITE;
        3'b000: cmd = CMD_MRS;
        // R19 no operation
        3'b111: cmd = CMD_NOP;
        default: cmd = CMD_OTHER;
      endcase
    end
  end

  // commands act only with decoder enabled and clock running both cycles
  assign cmd_live = dec_en && run && clock_gate_en;

  // ---------------- burst engine ----------------
  logic busy; // burst in progress
  logic is_write; // burst direction
  logic [3:0] beat; // current beat
  logic [3:0] blen; // burst length
  logic [BANK_W-1:0] bbank; // burst bank
  logic [COL_USED-1:0] bcol; // start column
  logic bap; // auto precharge after burst
  logic next_busy;
  logic next_is_write;
  logic [3:0] next_beat;
  logic [3:0] next_blen;
  logic [BANK_W-1:0] next_bbank;
  logic [COL_USED-1:0] next_bcol;
  logic next_bap;
  logic burst_end; // last beat this edge
  logic start; // column access accepted
  logic [NUM_BANKS-1:0] bank_open; // bank states seen as active

  // R16 column access to an open bank starts a burst
  assign start = cmd_live && !busy && (cmd == CMD_READ || cmd == CMD_WRITE) &&
                 bank_open[cmd_pins.bank_select];
  assign burst_end = busy && run && (beat == blen - 4'h1);

  // next burst state
  always_comb begin
    next_busy = busy;
    next_is_write = is_write;
    next_beat = beat;
    next_blen = blen;
    next_bbank = bbank;
    next_bcol = bcol;
    next_bap = bap;
    if (start) begin
      next_busy = 1'b1;
      // R6 write select low means write
      next_is_write = (cmd == CMD_WRITE);
      next_beat = 4'h0;
      // R1 burst chop pin low chops
      next_blen = cmd_pins.addr[CHOP_BIT] ? BURST_FULL : BURST_CHOP;
      next_bbank = cmd_pins.bank_select;
      // R17 column address from low address pins
      next_bcol = cmd_pins.addr[COL_USED-1:0];
      // R15 auto precharge request
      next_bap = cmd_pins.addr[APRE_BIT];
    end else if (burst_end) begin
      next_busy = 1'b0;
      next_beat = 4'h0;
    end else if (busy && run) begin
      next_beat = beat + 4'h1;
    end
  end

  // burst registers
  always_ff @(posedge mem_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      busy <= 1'b0;
      is_write <= 1'b0;
      beat <= 4'h0;
      blen <= BURST_FULL;
      bbank <= '0;
      bcol <= '0;
      bap <= 1'b0;
    end else begin
      busy <= next_busy;
      is_write <= next_is_write;
      beat <= next_beat;
      blen <= next_blen;
      bbank <= next_bbank;
      bcol <= next_bcol;
      bap <= next_bap;
    end
  end

  // ---------------- mode registers ----------------
  logic [ADDR_W-1:0] mode_reg_one;
  logic [ADDR_W-1:0] mode_reg_two;
  logic [ADDR_W-1:0] next_mode_reg_one;
  logic [ADDR_W-1:0] next_mode_reg_two;
  logic tstrb_on; // termination strobe enabled
  logic rtt_on; // some termination value programmed

  // R17 opcode loaded on mode register set, no bank active and no burst
  always_comb begin
    next_mode_reg_one = mode_reg_one;
    next_mode_reg_two = mode_reg_two;
    if (cmd_live && cmd == CMD_MRS && bank_open == '0 && !busy) begin
      if (cmd_pins.bank_select == MR_ONE_SEL) begin
        next_mode_reg_one = cmd_pins.addr;
      end else if (cmd_pins.bank_select == MR_TWO_SEL) begin
        next_mode_reg_two = cmd_pins.addr;
      end
    end
  end

  // mode registers
  always_ff @(posedge mem_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mode_reg_one <= MR_RESET;
      mode_reg_two <= MR_RESET;
    end else begin
      mode_reg_one <= next_mode_reg_one;
      mode_reg_two <= next_mode_reg_two;
    end
  end

  // R9 bit eleven of mode_reg_one
  assign tstrb_on = mode_reg_one[TSTRB_BIT];
  // R13 both termination fields off disables termination
  assign rtt_on = |(mode_reg_one & ONE_RTT_MASK) || |(mode_reg_two & TWO_RTT_MASK);

  // ---------------- banks ----------------
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANKS; gb = gb + 1) begin : g_bank
      sdpc_bank_st_t st;
      sdpc_bank_st_t next_st;
      logic [ADDR_W-1:0] row;
      logic [ADDR_W-1:0] next_row;
      logic [3:0] cnt;
      logic [3:0] next_cnt;
      logic hit; // bank pins select this bank
      logic pre_hit; // precharge reaches this bank
      logic apre_hit; // auto precharge at burst end

      assign hit = (cmd_pins.bank_select == BANK_W'(gb));
      // R15 precharge all when auto precharge select high
      assign pre_hit = cmd_live && cmd == CMD_PRECHARGE && (cmd_pins.addr[APRE_BIT] || hit);
      assign apre_hit = burst_end && bap && (bbank == BANK_W'(gb));

      // next bank state
      always_comb begin
        next_st = st;
        next_row = row;
        next_cnt = cnt;
        unique case (st)
          BANK_IDLE: begin
            // R4 activate opens the bank and latches the row
            if (cmd_live && cmd == CMD_ACTIVATE && hit) begin
              next_st = BANK_ACTIVE;
              next_row = cmd_pins.addr;
            end
          end
          BANK_ACTIVE: begin
            // R5 precharge starts closing
            if (pre_hit || apre_hit) begin
              next_st = BANK_PRECHG;
              next_cnt = PRE_LAST;
            end
          end
          BANK_PRECHG: begin
            // R5 idle once precharge time has passed
            if (run) begin
              if (cnt == 4'h0) begin
                next_st = BANK_IDLE;
              end else begin
                next_cnt = cnt - 4'h1;
              end
            end
          end
        endcase
      end

      // bank registers
      always_ff @(posedge mem_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
          st <= BANK_IDLE;
          row <= '0;
          cnt <= 4'h0;
        end else begin
          st <= next_st;
          row <= next_row;
          cnt <= next_cnt;
        end
      end

      assign bank_open[gb] = (st == BANK_ACTIVE);
    end
  endgenerate

  // ---------------- data path ----------------
  logic [MEM_AW-1:0] mem_addr;
  logic [COL_USED-1:0] cur_col;
  logic mem_we;
  logic mem_re;
  logic strobe_ok; // controller strobe pair differential
  logic [DATA_W-1:0] mem_rdata;

  assign cur_col = bcol + COL_USED'(beat);
  assign mem_addr = {bbank, cur_col};
  // R7 write beats qualified by the controller strobe pair
  assign strobe_ok = data_strobe_in ^ data_strobe_n_in;
  // R10 masked beat is dropped, R8 mask unused with termination strobe
  assign mem_we = busy && is_write && run && strobe_ok && !(byte_mask && !tstrb_on);
  assign mem_re = busy && !is_write && run;

  // R11 byte store behind the data pins
  sdpc_mem u_mem (
    .clk(mem_clk),
    .rst_n(link_rst_n),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(data_pins_in),
    .rdata(mem_rdata)
  );

  // read drive and strobe
  logic rd_drive;
  logic strobe_q;
  logic next_rd_drive;
  logic next_strobe_q;
  logic next_termination_on;
  logic next_term_strobe_en;

  // R7 strobe toggles with each read beat
  always_comb begin
    next_rd_drive = rd_drive;
    next_strobe_q = strobe_q;
    if (run) begin
      next_rd_drive = mem_re;
      next_strobe_q = mem_re ? !strobe_q : 1'b0;
    end
    // R12 registered enable applies termination
    next_termination_on = dte_q && rtt_on;
    next_term_strobe_en = tstrb_on;
  end

  // output registers
  always_ff @(posedge mem_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_drive <= 1'b0;
      strobe_q <= 1'b0;
      termination_on <= 1'b0;
      term_strobe_en <= 1'b0;
    end else begin
      rd_drive <= next_rd_drive;
      strobe_q <= next_strobe_q;
      termination_on <= next_termination_on;
      term_strobe_en <= next_term_strobe_en;
    end
  end

  assign data_pins_out = mem_rdata;
  assign data_pins_oe = rd_drive;
  assign data_strobe_out = strobe_q;
  assign data_strobe_n_out = !strobe_q;
  assign data_strobe_oe = rd_drive;
  assign data_strobe_n_oe = rd_drive;

  // ---------------- link to bus crossing ----------------
  sdpc_status_t st_link; // status in link domain
  sdpc_status_t st_meta; // first stage, read only by second
  sdpc_status_t st_bus; // status in bus domain

  assign st_link = '{busy: busy, term_strobe_en: term_strobe_en,
                     termination_on: termination_on, bank_active: bank_open};

  // two flops per independent status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_meta <= '0;
      st_bus <= '0;
    end else begin
      st_meta <= st_link;
      st_bus <= st_meta;
    end
  end

  // ---------------- apb slave ----------------
  logic [31:0] next_prdata;
  logic next_ctrl_decode_en;
  logic mapped;
  logic setup;

  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS);
  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data captured in setup, control written in access
  always_comb begin
    next_prdata = prdata;
    next_ctrl_decode_en = ctrl_decode_en;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (paddr == OFS_CTRL) begin
        next_prdata[CTRL_DECODE_EN_BIT] = ctrl_decode_en;
      end else if (paddr == OFS_STATUS) begin
        next_prdata[ST_W-1:0] = st_bus;
      end
    end
    if (psel && penable && pwrite && paddr == OFS_CTRL) begin
      next_ctrl_decode_en = pwdata[CTRL_DECODE_EN_BIT];
    end
  end

  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      ctrl_decode_en <= CTRL_RESET[CTRL_DECODE_EN_BIT];
    end else begin
      prdata <= next_prdata;
      ctrl_decode_en <= next_ctrl_decode_en;
    end
  end

endmodule

// file: bench/sdpc_monitor.sv
// port checker for the sdram pin command decoder
`timescale 1ns/1ps
module sdpc_monitor
  import sdpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic mem_clk,
  input wire logic mem_reset_n,
  input wire sdpc_cmd_pins_t cmd_pins,
  input wire logic data_pins_oe,
  input wire logic data_strobe_out,
  input wire logic data_strobe_oe,
  input wire logic data_strobe_n_out,
  input wire logic termination_on,
  input wire logic term_strobe_en
);
  // command code as seen on the four strobe pins
  wire [3:0] code = {cmd_pins.chip_sel_n, cmd_pins.row_strobe_n,
    cmd_pins.column_strobe_n, cmd_pins.write_sel_n};
  wire rd_cmd = code == 4'h5;
  wire ms1_cmd = code == 4'h0 && cmd_pins.bank_select == MR_ONE_SEL;
  // bus address that hits no register
  wire bad_addr = paddr != OFS_CTRL && paddr != OFS_STATUS;

  property p_rd_start;
    @(posedge mem_clk) disable iff (!mem_reset_n) $rose(data_pins_oe) |-> $past(rd_cmd, 2);
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("burst without read");
  property p_full;
    @(posedge mem_clk) disable iff (!mem_reset_n) $rose(data_pins_oe) &&
      $past(cmd_pins.addr[CHOP_BIT], 2) |-> data_pins_oe[*8] ##1 !data_pins_oe;
  endproperty
  a_full: assert property (p_full) else $error("full burst length");
  property p_chop;
    @(posedge mem_clk) disable iff (!mem_reset_n) $rose(data_pins_oe) &&
      !$past(cmd_pins.addr[CHOP_BIT], 2) |-> data_pins_oe[*4] ##1 !data_pins_oe;
  endproperty
  a_chop: assert property (p_chop) else $error("chopped burst length");
  property p_toggle;
    @(posedge mem_clk) disable iff (!mem_reset_n) data_strobe_oe && $past(data_strobe_oe)
      |-> data_strobe_out != $past(data_strobe_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("strobe not toggling");
  property p_pair;
    @(posedge mem_clk) disable iff (!mem_reset_n)
      data_strobe_oe |-> data_strobe_n_out == !data_strobe_out;
  endproperty
  a_pair: assert property (p_pair) else $error("strobe pair not inverse");
  property p_tstrb;
    @(posedge mem_clk) disable iff (!mem_reset_n) $changed(term_strobe_en) |->
      $past(ms1_cmd, 2) && term_strobe_en == $past(cmd_pins.addr[TSTRB_BIT], 2);
  endproperty
  a_tstrb: assert property (p_tstrb) else $error("term strobe change");
  property p_mreset;
    @(posedge pclk) disable iff (!presetn) !mem_reset_n |->
      !data_pins_oe && !data_strobe_oe && !term_strobe_en && !termination_on;
  endproperty
  a_mreset: assert property (p_mreset) else $error("device reset ignored");
  property p_slverr;
    @(posedge pclk) disable iff (!presetn) psel && penable && bad_addr |->
      pslverr && prdata == '0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access answer");
  // main scenarios reached
  c_full: cover property (@(posedge mem_clk) $rose(data_pins_oe) &&
    $past(cmd_pins.addr[CHOP_BIT], 2));
  c_tstrb: cover property (@(posedge mem_clk) $rose(term_strobe_en));
  c_bad: cover property (@(posedge pclk) psel && penable && pslverr);
endmodule
bind sdpc_top sdpc_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pslverr, .mem_clk, .mem_reset_n, .cmd_pins, .data_pins_oe, .data_strobe_out,
  .data_strobe_oe, .data_strobe_n_out, .termination_on, .term_strobe_en);

// file: bench/sdpc_ctl_model.sv
// memory controller model driving the device pins
`timescale 1ns/1ps
module sdpc_ctl_model
  import sdpc_pkg::*;
(
  input wire logic mem_clk,
  output logic mem_reset_n,
  output logic clock_gate_en,
  output sdpc_cmd_pins_t cmd_pins,
  output logic byte_mask,
  output logic [DATA_W-1:0] data_pins_in,
  output logic data_strobe_in,
  output logic data_strobe_n_in,
  input wire logic [DATA_W-1:0] data_pins_out
);
  logic busy; // a write burst owns the data lines
  initial begin
    mem_reset_n = 1'b0;
    clock_gate_en = 1'b1;
    cmd_pins = {4'h7, 17'h0_0000};
    byte_mask = 1'b0;
    data_pins_in = 8'h5a;
    data_strobe_in = 1'b0;
    data_strobe_n_in = 1'b0;
    busy = 1'b0;
  end
  // released data lines change every cycle
  always @(posedge mem_clk) begin
    if (!busy) begin
      data_pins_in <= ~data_pins_in;
    end
  end
  task automatic reset_pin();
    @(posedge mem_clk);
    mem_reset_n <= 1'b0;
    repeat (2) @(posedge mem_clk);
    mem_reset_n <= 1'b1;
    repeat (3) @(posedge mem_clk);
  endtask
  // one command cycle, then no operation
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge mem_clk);
    cmd_pins <= {c, b, a};
    @(posedge mem_clk);
    cmd_pins <= {4'h7, 17'h0_0000};
  endtask
  task automatic gate(input logic v);
    @(posedge mem_clk);
    clock_gate_en <= v;
  endtask
  task automatic wr(input logic [2:0] b, input logic [13:0] a, input logic [7:0] d [8],
    input logic [7:0] m, input int n);
    busy = 1'b1;
    cmd(4'h4, b, a);
    for (int k = 0; k < n; k++) begin
      data_pins_in <= d[k];
      byte_mask <= m[k];
      data_strobe_in <= ~k[0];
      data_strobe_n_in <= k[0];
      @(posedge mem_clk);
    end
    byte_mask <= 1'b0;
    data_strobe_n_in <= 1'b0;
    busy = 1'b0;
  endtask
  // read beats taken just after each edge
  task automatic rd(input logic [2:0] b, input logic [13:0] a, input int n,
    output logic [7:0] q [8]);
    cmd(4'h5, b, a);
    for (int k = 0; k < n; k++) begin
      @(posedge mem_clk);
      #1;
      q[k] = data_pins_out;
    end
  endtask
endmodule

// file: bench/sdpc_top_bench.sv
// self-checking bench for the sdram pin command decoder
`timescale 1ns/1ps
module sdpc_top_bench
  import sdpc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mem_clk, mem_reset_n, clock_gate_en, die_termination_en, byte_mask;
  sdpc_cmd_pins_t cmd_pins;
  logic [DATA_W-1:0] data_pins_in, data_pins_out;
  logic data_pins_oe, data_strobe_in, data_strobe_out, data_strobe_oe, termination_on;
  logic data_strobe_n_in, data_strobe_n_out, data_strobe_n_oe, term_strobe_en;
  int errors, checked;
  logic [7:0] pa [8], pb [8], q [8];

  sdpc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_clk, .mem_reset_n, .clock_gate_en, .cmd_pins,
    .die_termination_en, .byte_mask, .data_pins_in, .data_pins_out, .data_pins_oe,
    .data_strobe_in, .data_strobe_out, .data_strobe_oe, .data_strobe_n_in,
    .data_strobe_n_out, .data_strobe_n_oe, .termination_on, .term_strobe_en);
  sdpc_ctl_model u_ctl (.mem_clk, .mem_reset_n, .clock_gate_en, .cmd_pins, .byte_mask,
    .data_pins_in, .data_strobe_in, .data_strobe_n_in, .data_pins_out);

  // bus clock, and a link clock of unrelated phase
  always #20 pclk = ~pclk;
  initial begin
    mem_clk = 1'b0;
    #7;
    forever #80 mem_clk = ~mem_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one bus transfer, held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    chk(32'(n < 20), 32'h1, "ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // all eleven status bits once the crossing settles
  task automatic sts(input logic [31:0] exp);
    repeat (4) @(posedge mem_clk);
    apb(1'b0, OFS_STATUS, '0);
    chk(32'(rd[10:0]), exp, "banks");
  endtask

  task automatic t_regs();
    apb(1'b0, OFS_CTRL, '0);
    chk(rd, CTRL_RESET, "ctrl");
    apb(1'b1, 12'h008, 32'hffff_ffff);
    chk(32'(err), 32'h1, "unmapped err");
    apb(1'b0, 12'h008, '0);
    chk(rd, '0, "unmapped rd");
    $display("test registers done");
  endtask
  task automatic t_act();
    u_ctl.cmd(4'hb, 3'h3, '0);
    u_ctl.cmd(4'h7, 3'h3, '0);
    sts('0);
    u_ctl.cmd(4'h3, 3'h3, '0);
    sts(32'h0000_0008);
    u_ctl.gate(1'b0);
    u_ctl.cmd(4'h3, 3'h5, '0);
    u_ctl.gate(1'b1);
    sts(32'h0000_0008);
    apb(1'b1, OFS_CTRL, '0);
    repeat (2) @(posedge mem_clk);
    u_ctl.cmd(4'h3, 3'h6, '0);
    sts(32'h0000_0008);
    apb(1'b1, OFS_CTRL, CTRL_RESET);
    repeat (2) @(posedge mem_clk);
    $display("test activate done");
  endtask
  task automatic t_wr();
    for (int k = 0; k < 8; k++) begin
      pa[k] = 8'h10 + 8'(k);
      pb[k] = 8'ha0 + 8'(k);
    end
    u_ctl.wr(3'h3, 14'h1000, pa, 8'h00, 8);
    u_ctl.wr(3'h3, 14'h1000, pb, 8'h24, 8);
    u_ctl.wr(3'h3, 14'h0000, pa, 8'h00, 4);
    u_ctl.rd(3'h3, 14'h1000, 8, q);
    for (int k = 0; k < 8; k++) begin
      chk(32'(q[k]), 32'((k < 4 || k == 5) ? pa[k] : pb[k]), "beat");
    end
    u_ctl.rd(3'h3, 14'h0000, 4, q);
    @(posedge mem_clk);
    #1;
    chk(32'({data_pins_oe, data_strobe_n_oe}), '0, "chop end");
    $display("test data done");
  endtask
  task automatic t_pre();
    u_ctl.cmd(4'h2, 3'h3, '0);
    sts('0);
    u_ctl.cmd(4'h3, 3'h1, '0);
    u_ctl.cmd(4'h3, 3'h4, '0);
    sts(32'h0000_0012);
    u_ctl.cmd(4'h2, 3'h0, 14'h0400);
    sts('0);
    u_ctl.cmd(4'h3, 3'h2, '0);
    u_ctl.wr(3'h2, 14'h1400, pa, 8'h00, 8);
    sts('0);
    $display("test precharge done");
  endtask
  task automatic t_mode();
    u_ctl.cmd(4'h0, MR_ONE_SEL, 14'h0800);
    @(posedge mem_clk);
    die_termination_en <= 1'b1;
    repeat (3) @(posedge mem_clk);
    #1;
    chk(32'(term_strobe_en), 32'h1, "tstrb on");
    chk(32'(termination_on), '0, "rtt off");
    sts(32'h0000_0200);
    u_ctl.cmd(4'h0, MR_ONE_SEL, 14'h0804);
    repeat (3) @(posedge mem_clk);
    #1;
    chk(32'(termination_on), 32'h1, "rtt on");
    u_ctl.cmd(4'h3, 3'h0, '0);
    u_ctl.wr(3'h0, 14'h1008, pb, 8'hff, 8);
    u_ctl.rd(3'h0, 14'h1008, 8, q);
    for (int k = 0; k < 8; k++) begin
      chk(32'(q[k]), 32'(pb[k]), "mask off");
    end
    u_ctl.reset_pin();
    chk(32'(term_strobe_en), '0, "reset tstrb");
    sts('0);
    $display("test mode done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    #800000;
    errors++;
    results();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    die_termination_en = 1'b0;
    errors = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    u_ctl.reset_pin();
    t_regs();
    t_act();
    t_wr();
    t_pre();
    t_mode();
    results();
  end
endmodule
